// ===== bench/pll_feedback_divider_status_mux_test.sv
// Self-checking bench for the feedback divider and status mux
`timescale 1ns/1ps
`default_nettype none
module pll_feedback_divider_status_mux_test;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic [pll_fb_pkg::A_W-1:0] a_value_in = '0;
    logic [pll_fb_pkg::B_W-1:0] b_value_in = 13'h0002;
    logic [pll_fb_pkg::R_W-1:0] r_value_in = 14'h0003;
    logic first_reference_input_in = 1'b0;
    logic second_reference_input_in = 1'b0;
    logic diff_mode_in = 1'b0;
    logic ref_select_in = 1'b0;
    logic pfd_up_in = 1'b0;
    logic pfd_down_in = 1'b0;
    logic n_div_out;
    logic r_div_out;
    logic status_out;
    int seed = 79;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    pll_feedback_divider_status_mux u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .a_value_in(a_value_in), .b_value_in(b_value_in),
        .r_value_in(r_value_in), .first_reference_input_in(first_reference_input_in), .second_reference_input_in(second_reference_input_in),
        .diff_mode_in(diff_mode_in), .ref_select_in(ref_select_in), .pfd_up_in(pfd_up_in),
        .pfd_down_in(pfd_down_in), .n_div_out(n_div_out), .r_div_out(r_div_out),
        .status_out(status_out));
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // Free-running noise on the references and phase detector
    always @(posedge clk_sys_in) begin
        first_reference_input_in <= 1'($random(seed));
        second_reference_input_in <= 1'($random(seed));
        pfd_up_in <= 1'($random(seed));
        pfd_down_in <= 1'($random(seed));
    end
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cyc;
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        cyc();
        check(reg_rdata_out, e, "rdata");
    endtask
    // Cycles between two feedback pulses; bounded so a dead divider cannot hang
    task automatic period(output int p);
        int k;
        k = 0;
        while (n_div_out !== 1'b1 && k < 3000) begin
            cyc();
            k++;
        end
        cyc();
        p = 1;
        while (n_div_out !== 1'b1 && p < 3000) begin
            cyc();
            p++;
        end
    endtask
    function automatic int exp_n(input logic [2:0] pc, input bit byp, input int a, input int b);
        int p;
        int bb;
        case (pc)
            3'h0: p = 1;
            3'h1: p = 2;
            3'h7: p = 3;
            default: p = 1 << (pc - 1);
        endcase
        bb = (b < 2) ? 1 : b;
        if (byp) begin
            return p;
        end
        return (pc inside {[3'h2:3'h6]}) ? p * bb + a : p * bb;
    endfunction
    function automatic logic exp_st(input logic [5:0] c, input logic [3:0] v);
        case (c)
            6'h05: return v[2];
            6'h06: return v[3];
            6'h21: return v[0];
            6'h22: return diff_mode_in ? 1'b0 : v[1];
            6'h23: return (diff_mode_in | ~ref_select_in) ? v[0] : v[1];
            6'h24: return diff_mode_in ? 1'b0 : (ref_select_in ? v[0] : v[1]);
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        int a;
        int b;
        int p;
        int sc;
        int dc;
        logic [2:0] pc;
        logic [3:0] prev;
        static logic [5:0] codes[11] = '{6'h00, 6'h05, 6'h06, 6'h07, 6'h1f, 6'h20, 6'h21, 6'h22,
            6'h23, 6'h24, 6'h3f};
        repeat (6) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        rd(8'h16, 8'h00);
        rd(8'h17, 8'h00);
        rd(8'h40, 8'h00);
        wr(8'h17, 8'h1b);
        rd(8'h17, 8'h18);
        for (int i = 0; i < 17; i++) begin
            pc = i[2:0];
            b = (i == 16) ? 70 : 2 + $unsigned($random(seed)) % 8;
            a = (i == 16) ? 63 : $unsigned($random(seed)) % (b + 1);
            pc = (i == 16) ? 3'h2 : pc;
            a_value_in <= a[5:0];
            b_value_in <= b[12:0];
            wr(8'h16, {5'h00, pc});
            period(p);
            period(p);
            check(p, exp_n(pc, 1'b0, a, b), "n_period");
        end
        // Bypass only with a fixed-divide code, never dual modulus
        for (int i = 0; i < 2; i++) begin
            pc = i ? 3'h7 : 3'h1;
            wr(8'h16, {5'h01, pc});
            period(p);
            period(p);
            check(p, exp_n(pc, 1'b1, 0, 0), "bypass_period");
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h16, (i == 0) ? 8'h21 : (i == 1) ? 8'h11 : 8'h01);
            cyc();
            sc = 0;
            dc = 0;
            repeat (300) begin
                cyc();
                sc += int'(n_div_out);
                dc += int'(r_div_out);
            end
            check(sc == 0, i < 2, "n_held");
            check(dc == 0, i == 1, "r_held");
        end
        b_value_in <= 13'h0003;
        // Fixed divide-by-2 here: A phase stays low, prescaler pulses every other cycle
        for (int c = 1; c < 5; c++) begin
            wr(8'h17, {6'(c), 2'b00});
            cyc();
            cyc();
            sc = 0;
            dc = 0;
            repeat (200) begin
                cyc();
                sc += int'(status_out);
                dc += int'((c == 1) ? n_div_out : r_div_out);
            end
            if (c < 3) begin
                check(dc > 0 && sc - dc <= 1 && dc - sc <= 1, 1, "div_on_status");
            end else if (c == 3) begin
                check(sc, 0, "a_on_status");
            end else begin
                check(sc >= 99 && sc <= 101, 1, "pre_on_status");
            end
        end
        foreach (codes[j]) begin
            diff_mode_in <= 1'($random(seed));
            ref_select_in <= 1'($random(seed));
            wr(8'h17, {codes[j], 2'b00});
            cyc();
            cyc();
            prev = {pfd_down_in, pfd_up_in, second_reference_input_in, first_reference_input_in};
            repeat (24) begin
                cyc();
                check(status_out, exp_st(codes[j], prev), "status");
                prev = {pfd_down_in, pfd_up_in, second_reference_input_in, first_reference_input_in};
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire

// ===== core/pll_feedback_divider_status_mux.sv
// PLL feedback divider, reference divider, control registers and status pin mux
`timescale 1ns/1ps
`default_nettype none
module pll_feedback_divider_status_mux #(
    parameter int DLY_STAGES = 1
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [pll_fb_pkg::A_W-1:0] a_value_in,
    input wire logic [pll_fb_pkg::B_W-1:0] b_value_in,
    input wire logic [pll_fb_pkg::R_W-1:0] r_value_in,
    input wire logic first_reference_input_in,
    input wire logic second_reference_input_in,
    input wire logic diff_mode_in,
    input wire logic ref_select_in,
    input wire logic pfd_up_in,
    input wire logic pfd_down_in,
    output logic n_div_out,
    output logic r_div_out,
    output logic status_out
);
    typedef struct packed {
        logic [7:0] fb_ctrl;
        logic [7:0] stat_sel;
        logic [7:0] rdata;
        logic [pll_fb_pkg::PRE_W-1:0] pre_cnt;
        logic [pll_fb_pkg::A_W-1:0] a_cnt;
        logic [pll_fb_pkg::B_W-1:0] b_cnt;
        logic [pll_fb_pkg::R_W-1:0] r_cnt;
        logic pre_out;
        logic a_out;
        logic n_pulse;
        logic r_pulse;
        logic [DLY_STAGES-1:0] n_dly;
        logic [DLY_STAGES-1:0] r_dly;
        logic ref_prev;
        logic status;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic [5:0] base_ratio(input logic [2:0] code);
        case (code)
            pll_fb_pkg::PRE_FD1: base_ratio = pll_fb_pkg::RATIO_1;
            pll_fb_pkg::PRE_FD2: base_ratio = pll_fb_pkg::RATIO_2;
            pll_fb_pkg::PRE_DM2: base_ratio = pll_fb_pkg::RATIO_2;
            pll_fb_pkg::PRE_DM4: base_ratio = pll_fb_pkg::RATIO_4;
            pll_fb_pkg::PRE_DM8: base_ratio = pll_fb_pkg::RATIO_8;
            pll_fb_pkg::PRE_DM16: base_ratio = pll_fb_pkg::RATIO_16;
            pll_fb_pkg::PRE_DM32: base_ratio = pll_fb_pkg::RATIO_32;
            default: base_ratio = pll_fb_pkg::RATIO_3;
        endcase
    endfunction

    function automatic logic is_dual(input logic [2:0] code);
        is_dual = (code != pll_fb_pkg::PRE_FD1) && (code != pll_fb_pkg::PRE_FD2)
            && (code != pll_fb_pkg::PRE_FD3);
    endfunction

    logic [2:0] pre_code;
    logic dm;
    logic bypass;
    logic rst_ab;
    logic rst_all;
    logic a_phase;
    logic [5:0] modulus;
    logic pre_tc;
    logic ref_now;
    logic ref_edge;
    logic [5:0] sel;

    always_comb begin
        pre_code = st.fb_ctrl[pll_fb_pkg::PRE_MSB:0];
        dm = is_dual(pre_code);
        bypass = st.fb_ctrl[pll_fb_pkg::BIT_B_BYPASS];
        rst_ab = st.fb_ctrl[pll_fb_pkg::BIT_RESET_AB];
        rst_all = st.fb_ctrl[pll_fb_pkg::BIT_RESET_ALL];
        // A only counts in dual-modulus mode; fixed ratios ignore it
        a_phase = dm && (st.a_cnt < a_value_in) && !rst_ab && !rst_all;
        modulus = base_ratio(pre_code) + {5'h00, a_phase};
        pre_tc = (st.pre_cnt == modulus - 6'h01);
        // Differential reference arrives on the first input
        ref_now = (ref_select_in && !diff_mode_in) ? second_reference_input_in : first_reference_input_in;
        ref_edge = ref_now && !st.ref_prev;
        sel = st.stat_sel[pll_fb_pkg::SEL_MSB:pll_fb_pkg::SEL_LSB];
    end

    always_comb begin
        next_st = st;
        next_st.n_pulse = 1'b0;
        next_st.r_pulse = 1'b0;
        if (reg_wr_in) begin
            if (reg_addr_in == pll_fb_pkg::ADDR_FB_CTRL) begin
                next_st.fb_ctrl = reg_wdata_in;
            end else if (reg_addr_in == pll_fb_pkg::ADDR_STAT_SEL) begin
                next_st.stat_sel = reg_wdata_in;
            end
        end
        if (reg_addr_in == pll_fb_pkg::ADDR_FB_CTRL) begin
            next_st.rdata = st.fb_ctrl;
        end else if (reg_addr_in == pll_fb_pkg::ADDR_STAT_SEL) begin
            // Low two bits are unused and read as zero
            next_st.rdata = {sel, 2'b00};
        end else begin
            next_st.rdata = 8'h00;
        end
        // Prescaler
        next_st.pre_cnt = pre_tc ? '0 : st.pre_cnt + 6'h01;
        next_st.pre_out = pre_tc;
        // A and B counters, clocked by prescaler terminal count
        if (rst_ab || rst_all) begin
            next_st.a_cnt = '0;
            next_st.b_cnt = '0;
        end else if (pre_tc) begin
            if (bypass) begin
                next_st.n_pulse = 1'b1;
                next_st.b_cnt = '0;
                next_st.a_cnt = '0;
            end else if ({1'b0, st.b_cnt} + 14'h0001 >= {1'b0, b_value_in}) begin
                next_st.n_pulse = 1'b1;
                next_st.b_cnt = '0;
                next_st.a_cnt = '0;
            end else begin
                next_st.b_cnt = st.b_cnt + 13'h0001;
                if (a_phase) begin
                    next_st.a_cnt = st.a_cnt + 6'h01;
                end
            end
        end
        next_st.a_out = a_phase;
        // R counter on rising reference edges
        next_st.ref_prev = ref_now;
        if (rst_all) begin
            next_st.r_cnt = '0;
        end else if (ref_edge) begin
            if ({1'b0, st.r_cnt} + 15'h0001 >= {1'b0, r_value_in}) begin
                next_st.r_cnt = '0;
                next_st.r_pulse = 1'b1;
            end else begin
                next_st.r_cnt = st.r_cnt + 14'h0001;
            end
        end
        // Programmable path delay modelled as a short shift line
        // Oldest stage drops off the top of the line
        next_st.n_dly = DLY_STAGES'({st.n_dly, st.n_pulse});
        next_st.r_dly = DLY_STAGES'({st.r_dly, st.r_pulse});
        // Status pin select
        if (sel == pll_fb_pkg::SEL_N_DIV) begin
            next_st.status = st.n_dly[DLY_STAGES-1];
        end else if (sel == pll_fb_pkg::SEL_R_DIV) begin
            next_st.status = st.r_dly[DLY_STAGES-1];
        end else if (sel == pll_fb_pkg::SEL_A_DIV) begin
            next_st.status = st.a_out;
        end else if (sel == pll_fb_pkg::SEL_PRE) begin
            next_st.status = st.pre_out;
        end else if (sel == pll_fb_pkg::SEL_PFD_UP) begin
            next_st.status = pfd_up_in;
        end else if (sel == pll_fb_pkg::SEL_PFD_DN) begin
            next_st.status = pfd_down_in;
        end else if (sel == pll_fb_pkg::SEL_FIRST_REFERENCE_INPUT_CLK) begin
            next_st.status = first_reference_input_in;
        end else if (sel == pll_fb_pkg::SEL_SECOND_REFERENCE_INPUT_CLK) begin
            next_st.status = second_reference_input_in && !diff_mode_in;
        end else if (sel == pll_fb_pkg::SEL_REF_SEL) begin
            next_st.status = ref_now;
        end else if (sel == pll_fb_pkg::SEL_REF_UNSEL) begin
            // Differential mode has no unselected reference, so pin stays low
            next_st.status = (ref_select_in && !diff_mode_in) ? first_reference_input_in
                : (second_reference_input_in && !diff_mode_in);
        end else begin
            // Monitor status selections live outside this block
            next_st.status = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st <= '0;
            st.fb_ctrl <= pll_fb_pkg::FB_CTRL_RESET;
            st.stat_sel <= pll_fb_pkg::STAT_SEL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign n_div_out = st.n_dly[DLY_STAGES-1];
    assign r_div_out = st.r_dly[DLY_STAGES-1];
    assign status_out = st.status;

    a_fd_ratio_two: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (pre_code == pll_fb_pkg::PRE_FD2 && pre_tc) |-> st.pre_cnt == 6'h01)
        else $error("fixed divide-by-2 terminal count wrong");
    a_fd_ratio_three: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (pre_code == pll_fb_pkg::PRE_FD3 && pre_tc) |-> st.pre_cnt == 6'h02 && !a_phase)
        else $error("fixed divide-by-3 terminal count wrong");
    a_dm_swallow_23: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (pre_code == pll_fb_pkg::PRE_DM2 && pre_tc)
        |-> st.pre_cnt == (a_value_in != '0 && a_phase ? 6'h02 : 6'h01))
        else $error("dual modulus 2/3 ratio wrong");
    a_dm_swallow_89: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (pre_code == pll_fb_pkg::PRE_DM8 && pre_tc && !rst_ab && !rst_all)
        |-> st.pre_cnt == (st.a_cnt < a_value_in ? 6'h08 : 6'h07))
        else $error("dual modulus 8/9 ratio wrong");
    a_bypass_n_pulse: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (bypass && pre_tc && !rst_ab && !rst_all) |=> st.n_pulse)
        else $error("bypassed B counter did not divide by one");
    a_ab_reset_hold: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (rst_ab || rst_all) |=> st.a_cnt == '0 && st.b_cnt == '0 && !st.n_pulse)
        else $error("A and B counters not held in reset");
    a_all_reset_r: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        rst_all |=> st.r_cnt == '0 && !st.r_pulse)
        else $error("R counter not held in reset");
    a_status_n_div: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        sel == pll_fb_pkg::SEL_N_DIV |=> status_out == $past(n_div_out))
        else $error("status pin not following feedback output");
    a_status_pfd_dn: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        sel == pll_fb_pkg::SEL_PFD_DN |=> status_out == $past(pfd_down_in))
        else $error("status pin not following PFD down");
    a_status_ground: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (!sel[5] && sel > pll_fb_pkg::SEL_PFD_DN || sel == pll_fb_pkg::SEL_GND
        || sel == pll_fb_pkg::SEL_MON_GND) |=> !status_out)
        else $error("status pin not static low");
    a_status_second_reference_input_diff: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (sel == pll_fb_pkg::SEL_SECOND_REFERENCE_INPUT_CLK && diff_mode_in) |=> !status_out)
        else $error("second reference shown in differential mode");
    a_status_unsel_diff: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (sel == pll_fb_pkg::SEL_REF_UNSEL && diff_mode_in) |=> !status_out)
        else $error("unselected reference shown in differential mode");
    c_bypass_pulse: cover property (@(posedge clk_sys_in) bypass && st.n_pulse);
    c_a_phase_end: cover property (@(posedge clk_sys_in) a_phase ##1 !a_phase && dm);
    c_status_pfd_up: cover property (@(posedge clk_sys_in)
        sel == pll_fb_pkg::SEL_PFD_UP ##1 status_out);
endmodule
`default_nettype wire

// ===== shared/pll_fb_pkg.sv
// Register map, field positions and encodings of the feedback divider block
package pll_fb_pkg;
    localparam logic [7:0] ADDR_FB_CTRL = 8'h16;
    localparam logic [7:0] ADDR_STAT_SEL = 8'h17;
    localparam logic [7:0] FB_CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_SEL_RESET = 8'h00;
    localparam int BIT_RESET_AB = 5;
    localparam int BIT_RESET_ALL = 4;
    localparam int BIT_B_BYPASS = 3;
    localparam int PRE_MSB = 2;
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 2;
    localparam int A_W = 6;
    localparam int B_W = 13;
    localparam int R_W = 14;
    localparam int PRE_W = 6;
    // Prescaler ratio codes
    localparam logic [2:0] PRE_FD1 = 3'h0;
    localparam logic [2:0] PRE_FD2 = 3'h1;
    localparam logic [2:0] PRE_DM2 = 3'h2;
    localparam logic [2:0] PRE_DM4 = 3'h3;
    localparam logic [2:0] PRE_DM8 = 3'h4;
    localparam logic [2:0] PRE_DM16 = 3'h5;
    localparam logic [2:0] PRE_DM32 = 3'h6;
    localparam logic [2:0] PRE_FD3 = 3'h7;
    localparam logic [5:0] RATIO_1 = 6'h01;
    localparam logic [5:0] RATIO_2 = 6'h02;
    localparam logic [5:0] RATIO_3 = 6'h03;
    localparam logic [5:0] RATIO_4 = 6'h04;
    localparam logic [5:0] RATIO_8 = 6'h08;
    localparam logic [5:0] RATIO_16 = 6'h10;
    localparam logic [5:0] RATIO_32 = 6'h20;
    // Status select codes
    localparam logic [5:0] SEL_GND = 6'h00;
    localparam logic [5:0] SEL_N_DIV = 6'h01;
    localparam logic [5:0] SEL_R_DIV = 6'h02;
    localparam logic [5:0] SEL_A_DIV = 6'h03;
    localparam logic [5:0] SEL_PRE = 6'h04;
    localparam logic [5:0] SEL_PFD_UP = 6'h05;
    localparam logic [5:0] SEL_PFD_DN = 6'h06;
    localparam logic [5:0] SEL_MON_GND = 6'h20;
    localparam logic [5:0] SEL_FIRST_REFERENCE_INPUT_CLK = 6'h21;
    localparam logic [5:0] SEL_SECOND_REFERENCE_INPUT_CLK = 6'h22;
    localparam logic [5:0] SEL_REF_SEL = 6'h23;
    localparam logic [5:0] SEL_REF_UNSEL = 6'h24;
endpackage
